// ==== hdl/vsc_params.svh ====
// register offsets, field positions, write masks and reset value of the scaler
`ifndef VSC_PARAMS_SVH
`define VSC_PARAMS_SVH

// register byte offsets
`define VSC_OFF_SCALE   16'h808c
`define VSC_OFF_PITCH   16'h8090
`define VSC_OFF_CROP    16'h8094
`define VSC_OFF_SRC     16'h8098
`define VSC_OFF_DST     16'h809c

// writable bits of each register, reserved bits stay zero
`define VSC_MSK_SCALE   32'he7ff_c7ff
`define VSC_MSK_PITCH   32'h1fff_1fff
`define VSC_MSK_CROP    32'h0fff_0fff
`define VSC_MSK_SRC     32'h00ff_ffff
`define VSC_MSK_DST     32'h00ff_ffff
`define VSC_REG_RST     32'h0000_0000

// field positions
`define VSC_K2          10:0
`define VSC_FILTER_ENABLE        15:14
`define VSC_K1          26:16
`define VSC_SENSE       29
`define VSC_HOST        30
`define VSC_SHRINK      31
`define VSC_DSTEP       12:0
`define VSC_SSTEP       28:16
`define VSC_LEN         11:0
`define VSC_CSTART      27:16
`define VSC_BASE        23:0
`define VSC_BUSY        31

// filter characteristic codes
`define VSC_FILTER_ENABLE_BILIN  2'b00
`define VSC_FILTER_ENABLE_02420  2'b01
`define VSC_FILTER_ENABLE_12221  2'b10

`endif

// ==== hdl/vsc_pkg.sv ====
// types shared by the scaler register block and its bench
package vsc_pkg;

    // engine states, one-hot
    typedef enum logic [3:0] {
        VSC_IDLE  = 4'b0001,
        VSC_FETCH = 4'b0010,
        VSC_STEP  = 4'b0100,
        VSC_WRITE = 4'b1000
    } vsc_state_t;

    // display memory request, held until acknowledged
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [23:0] addr;
        logic [7:0]  wdata;
    } vsc_mem_req_t;

    // host pixel byte stream
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } vsc_host_pix_t;

endpackage : vsc_pkg

// ==== hdl/vsc_param_regs.sv ====
// scaler parameter registers with the pixel engine they steer
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "vsc_params.svh"
// limitation: steps, crop and constants are read live, so software
// leaves them alone while busy; the bases and the accumulator start are sampled at start

module vsc_param_regs
    import vsc_pkg::*;
(
    // clock and reset
    input  wire logic          mclk_in,
    input  wire logic          sys_rst_in,
    // register port
    input  wire logic [15:0]   reg_addr_in,
    input  wire logic [31:0]   reg_wdata_in,
    input  wire logic          reg_wr_in,
    input  wire logic          reg_rd_in,
    output logic [31:0]        reg_rdata_out,
    // engine control from the surrounding engine
    input  wire logic          start_in,
    input  wire logic          filter_enable_in,
    input  wire logic          key_mask_enable_in,
    input  wire logic [11:0]   dda_init_in,
    input  wire logic          key_mask_in,
    // host pixel stream
    input  wire vsc_host_pix_t host_pix_in,
    output logic               host_ready_out,
    // display memory
    output vsc_mem_req_t       mem_req_out,
    input  wire logic          mem_ack_in,
    input  wire logic [7:0]    mem_rdata_in,
    // status
    output logic               busy_out
);

    // registers
    logic [31:0]  scale_q;
    logic [31:0]  pitch_q;
    logic [31:0]  crop_q;
    logic [31:0]  src_q;
    logic [31:0]  dst_q;
    logic [31:0]  rdata_q;
    // engine state
    vsc_state_t   state_q;
    vsc_state_t   state_d;
    logic         busy_q;
    logic [11:0]  acc_q;
    logic [23:0]  rd_addr_q;
    logic [23:0]  wr_addr_q;
    logic [1:0]   drop_q;
    logic [11:0]  out_cnt_q;
    logic         adv_q;
    logic         host_ready_q;
    vsc_mem_req_t mem_q;
    logic [7:0]   win_q [0:4];

    // address decode
    wire hit_scale = reg_addr_in == `VSC_OFF_SCALE;
    wire hit_pitch = reg_addr_in == `VSC_OFF_PITCH;
    wire hit_crop  = reg_addr_in == `VSC_OFF_CROP;
    wire hit_src   = reg_addr_in == `VSC_OFF_SRC;
    wire hit_dst   = reg_addr_in == `VSC_OFF_DST;

    // read select; unmapped offsets read zero
    wire [31:0] rd_mux = hit_scale ? scale_q :
                         hit_pitch ? pitch_q :
                         hit_crop  ? crop_q  :
                         hit_src   ? src_q   :
                         hit_dst   ? {busy_q, dst_q[30:0]} :
                         32'h0000_0000;

    // scaling constants and mode bits
    wire [10:0] k2         = scale_q[`VSC_K2];
    wire [1:0]  filter_enable_sel   = scale_q[`VSC_FILTER_ENABLE];
    wire [10:0] k1         = scale_q[`VSC_K1];
    wire        key_sense  = scale_q[`VSC_SENSE];
    wire        host_sel   = scale_q[`VSC_HOST];
    wire        shrink     = scale_q[`VSC_SHRINK];

    // memory steps
    wire [12:0] dstep      = pitch_q[`VSC_DSTEP];
    wire [12:0] sstep      = pitch_q[`VSC_SSTEP];

    // crop window and base addresses
    wire [11:0] crop_len   = crop_q[`VSC_LEN];
    wire [11:0] crop_start = crop_q[`VSC_CSTART];
    wire [23:0] src_base   = src_q[`VSC_BASE];
    wire [23:0] dst_base   = dst_q[`VSC_BASE];

    // state qualifiers
    wire in_idle  = state_q == VSC_IDLE;
    wire in_fetch = state_q == VSC_FETCH;
    wire in_step  = state_q == VSC_STEP;
    wire in_write = state_q == VSC_WRITE;
    // a start only counts from idle, so a start while busy is dropped
    wire start_go = in_idle && start_in;

    // pixel intake; memory when the host bit is clear, host otherwise
    // dropped host bytes are taken off the stream but never reach the window
    wire host_take = in_fetch && host_sel && host_pix_in.valid && host_ready_q;
    wire host_got  = host_take && (drop_q == 2'd0);
    wire mem_got   = in_fetch && !host_sel && mem_q.rd && mem_ack_in;
    wire got_pix   = host_got || mem_got;
    wire [7:0] new_pix = host_sel ? host_pix_in.data : mem_rdata_in;

    // ratio accumulator: overflow marks a consumed or an emitted pixel
    // twelve bits signed, so widths beyond the 11-bit constants would wrap
    wire [11:0] acc_sum = acc_q + {1'b0, k1};
    wire        ovf     = ~acc_sum[11];
    wire [11:0] acc_nxt = ovf ? acc_q + {k2[10], k2} : acc_sum;
    wire        emit    = !shrink || ovf;
    wire        adv     = shrink || ovf;
    wire        done    = out_cnt_q == crop_len;

    // write gating by crop start and key mask
    // a suppressed or keyed-out pixel still counts against the crop length
    wire suppress   = out_cnt_q < crop_start;
    wire show_video = key_mask_in ^ key_sense;
    wire key_block  = key_mask_enable_in && !show_video;
    wire skip_wr    = suppress || key_block;
    wire wr_ack     = in_write && mem_q.wr && mem_ack_in;
    wire wr_done    = in_write && (!mem_q.wr || mem_ack_in);

    // filter taps; window 0 is the newest pixel
    // divides round down; the lost fraction stays below one code step
    wire [10:0] f_bil   = {3'h0, win_q[0]} + {3'h0, win_q[1]};
    wire [10:0] f_02420 = {3'h0, win_q[1]} + {2'h0, win_q[2], 1'b0} + {3'h0, win_q[3]};
    wire [10:0] f_12221 = {3'h0, win_q[0]} + {2'h0, win_q[1], 1'b0} + {2'h0, win_q[2], 1'b0}
                        + {2'h0, win_q[3], 1'b0} + {3'h0, win_q[4]};
    // reserved code passes the newest pixel rather than guess a kernel
    wire [7:0] filter_enable_pix = (filter_enable_sel == `VSC_FILTER_ENABLE_BILIN) ? f_bil[8:1]   :
                          (filter_enable_sel == `VSC_FILTER_ENABLE_02420) ? f_02420[9:2] :
                          (filter_enable_sel == `VSC_FILTER_ENABLE_12221) ? f_12221[10:3] :
                          win_q[0];
    wire [7:0] pix_out  = filter_enable_in ? filter_enable_pix : win_q[0];

    // read address: base at start, source step after each read
    wire [23:0] rd_addr_d = start_go ? src_base :
                            mem_got  ? rd_addr_q + {11'h0, sstep} :
                            rd_addr_q;

    // write address: base at start, destination step after each acknowledged write
    wire [23:0] wr_addr_d = start_go ? dst_base :
                            wr_ack   ? wr_addr_q + {11'h0, dstep} :
                            wr_addr_q;

    // host bytes still to drop at the head of the line
    wire [1:0]  drop_d    = start_go ? (host_sel ? src_base[1:0] : 2'd0) :
                            (host_take && drop_q != 2'd0) ? drop_q - 2'd1 : drop_q;

    // output count, accumulator and busy flag
    wire [11:0] cnt_d     = start_go ? 12'h000 : wr_done ? out_cnt_q + 12'h001 : out_cnt_q;
    wire        last_out  = wr_done && (cnt_d == crop_len);
    wire [11:0] acc_d     = start_go ? dda_init_in : (in_step && !done) ? acc_nxt : acc_q;
    wire        busy_d    = start_go ? 1'b1 : (in_step && done) ? 1'b0 : busy_q;

    // memory request and host ready for the coming cycle
    wire        ready_d   = (state_d == VSC_FETCH) && host_sel;
    wire        rd_d      = (state_d == VSC_FETCH) && !host_sel;
    wire        wr_d      = (in_step && !done && emit && !skip_wr) ||
                            (in_write && mem_q.wr && !mem_ack_in);
    wire [23:0] maddr_d   = rd_d ? rd_addr_d : wr_addr_d;
    wire [7:0]  wdata_d   = in_step ? pix_out : mem_q.wdata;

    // register writes, masked so reserved bits stay zero
    // bit 31 of the destination word is never stored; busy comes from the engine
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            scale_q <= `VSC_REG_RST;
            pitch_q <= `VSC_REG_RST;
            crop_q  <= `VSC_REG_RST;
            src_q   <= `VSC_REG_RST;
            dst_q   <= `VSC_REG_RST;
        end else if (reg_wr_in) begin
            if (hit_scale) scale_q <= reg_wdata_in & `VSC_MSK_SCALE;
            if (hit_pitch) pitch_q <= reg_wdata_in & `VSC_MSK_PITCH;
            if (hit_crop)  crop_q  <= reg_wdata_in & `VSC_MSK_CROP;
            if (hit_src)   src_q   <= reg_wdata_in & `VSC_MSK_SRC;
            if (hit_dst)   dst_q   <= reg_wdata_in & `VSC_MSK_DST;
        end
    end

    // read data stands only in the cycle after the strobe
    // zero outside that cycle, so a shared read bus sees no stale word
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_rd_in ? rd_mux : 32'h0000_0000;
        end
    end

    // engine sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            VSC_IDLE: begin
                // a zero length still passes one step, which clears busy
                if (start_in) begin
                    state_d = (crop_len == 12'h000) ? VSC_STEP : VSC_FETCH;
                end
            end
            VSC_FETCH: begin
                if (got_pix) begin
                    state_d = VSC_STEP;
                end
            end
            VSC_STEP: begin
                if (done) begin
                    state_d = VSC_IDLE;
                end else begin
                    state_d = emit ? VSC_WRITE : VSC_FETCH;
                end
            end
            VSC_WRITE: begin
                // after the last output go straight to the closing step, no extra source fetch
                if (wr_done) begin
                    state_d = (adv_q && !last_out) ? VSC_FETCH : VSC_STEP;
                end
            end
            default: begin
                state_d = VSC_IDLE;
            end
        endcase
    end

    // engine state and counters
    // adv_q remembers whether the last step used up its source pixel
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_q   <= VSC_IDLE;
            busy_q    <= 1'b0;
            acc_q     <= 12'h000;
            out_cnt_q <= 12'h000;
            drop_q    <= 2'd0;
            adv_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            busy_q    <= busy_d;
            acc_q     <= acc_d;
            out_cnt_q <= cnt_d;
            drop_q    <= drop_d;
            adv_q     <= in_step ? adv : adv_q;
        end
    end

    // addresses and memory request, held until acknowledged
    // request fields move only when the engine moves on, never while waiting
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rd_addr_q    <= 24'h00_0000;
            wr_addr_q    <= 24'h00_0000;
            host_ready_q <= 1'b0;
            mem_q        <= '0;
        end else begin
            rd_addr_q    <= rd_addr_d;
            wr_addr_q    <= wr_addr_d;
            host_ready_q <= ready_d;
            mem_q        <= '{rd: rd_d, wr: wr_d, addr: maddr_d, wdata: wdata_d};
        end
    end

    // pixel window for the filter taps, cleared per operation
    // the clear keeps pixels of the previous operation out of the first outputs
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || start_go) begin
            for (int i = 0; i < 5; i++) win_q[i] <= 8'h00;
        end else if (got_pix) begin
            win_q[0] <= new_pix;
            for (int i = 1; i < 5; i++) win_q[i] <= win_q[i-1];
        end
    end

    // outputs straight from flops
    assign reg_rdata_out  = rdata_q;
    assign host_ready_out = host_ready_q;
    assign mem_req_out    = mem_q;
    assign busy_out       = busy_q;

endmodule : vsc_param_regs
`default_nettype wire

// ==== testbench/vsc_param_regs_asserts.sv ====
// bound checker for the scaler parameter registers
`timescale 1ns/10ps
`default_nettype none
`include "vsc_params.svh"
module vsc_param_regs_asserts
    import vsc_pkg::*;
(
    // clock, reset and register port
    input wire logic          mclk_in,
    input wire logic          sys_rst_in,
    input wire logic [15:0]   reg_addr_in,
    input wire logic [31:0]   reg_wdata_in,
    input wire logic          reg_wr_in,
    input wire logic          reg_rd_in,
    input wire logic [31:0]   reg_rdata_out,
    // engine and memory
    input wire logic          start_in,
    input wire logic          host_ready_out,
    input wire vsc_mem_req_t  mem_req_out,
    input wire logic          mem_ack_in,
    input wire logic          busy_out
);
    logic [23:0] dst_q;
    logic [23:0] wlast_q;
    logic [12:0] dstep_q;
    logic        host_q;
    logic        wseen_q;
    logic [31:0] rmask_q;
    // readable bits per address; busy shows at the top of the destination word
    wire  [31:0] rmask_d = (reg_addr_in == `VSC_OFF_SCALE) ? `VSC_MSK_SCALE :
                           (reg_addr_in == `VSC_OFF_PITCH) ? `VSC_MSK_PITCH :
                           (reg_addr_in == `VSC_OFF_CROP)  ? `VSC_MSK_CROP  :
                           (reg_addr_in == `VSC_OFF_SRC)   ? `VSC_MSK_SRC   :
                           (reg_addr_in == `VSC_OFF_DST)   ? 32'h80ff_ffff  : 32'h0;
    // shadow of the fields the engine uses; only valid while software leaves them alone mid-run
    always_ff @(posedge mclk_in) begin
        rmask_q <= rmask_d;
        if (sys_rst_in) begin
            dst_q   <= 24'h0;
            dstep_q <= 13'h0;
            host_q  <= 1'b0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `VSC_OFF_DST) dst_q <= reg_wdata_in[`VSC_BASE];
            if (reg_addr_in == `VSC_OFF_PITCH) dstep_q <= reg_wdata_in[`VSC_DSTEP];
            if (reg_addr_in == `VSC_OFF_SCALE) host_q <= reg_wdata_in[`VSC_HOST];
        end
    end
    // last write address of the running operation; a start forgets it
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || (start_in && !busy_out)) begin
            wseen_q <= 1'b0;
        end else if (mem_req_out.wr && mem_ack_in) begin
            wseen_q <= 1'b1;
        end
        if (mem_req_out.wr && mem_ack_in) wlast_q <= mem_req_out.addr;
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_busy_readback: assert property (reg_rd_in && reg_addr_in == `VSC_OFF_DST
        |=> reg_rdata_out[31] == $past(busy_out)) else $error("busy bit read differs from busy output");
    a_reserved_zero: assert property (reg_rd_in |=> (reg_rdata_out & ~rmask_q) == 32'h0)
        else $error("reserved or unmapped bits read nonzero");
    a_start_busy: assert property (start_in && !busy_out |=> busy_out)
        else $error("busy did not follow start");
    a_idle_quiet: assert property (!busy_out |-> !mem_req_out.rd && !mem_req_out.wr && !host_ready_out)
        else $error("activity while not busy");
    a_host_noread: assert property (host_q |-> !mem_req_out.rd)
        else $error("memory read with host source");
    a_req_steady: assert property ((mem_req_out.rd || mem_req_out.wr) && !mem_ack_in |=> $stable(mem_req_out))
        else $error("memory request changed before ack");
    a_dst_first: assert property ($rose(mem_req_out.wr) && !wseen_q |-> mem_req_out.addr == dst_q)
        else $error("first write not at destination base");
    a_dst_step: assert property ($rose(mem_req_out.wr) && wseen_q
        |-> mem_req_out.addr == wlast_q + {11'h0, dstep_q}) else $error("write address step wrong");

    c_start: cover property (start_in && !busy_out);
    c_write: cover property (mem_req_out.wr && mem_ack_in);
    c_read: cover property (mem_req_out.rd && mem_ack_in);
endmodule : vsc_param_regs_asserts

bind vsc_param_regs vsc_param_regs_asserts u_chk (.mclk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .start_in, .host_ready_out, .mem_req_out, .mem_ack_in, .busy_out);
`default_nettype wire

// ==== testbench/vsc_far_model.sv ====
// display memory and host pixel source facing the scaler engine
`timescale 1ns/10ps
`default_nettype none
module vsc_far_model
    import vsc_pkg::*;
(
    // clock, reset and answer delay
    input  wire logic          mclk_in,
    input  wire logic          sys_rst_in,
    input  wire logic [1:0]    slow_in,
    // display memory
    input  wire vsc_mem_req_t  mem_req_in,
    output logic               mem_ack_out,
    output logic [7:0]         mem_rdata_out,
    // host pixel stream
    input  wire logic          host_ready_in,
    output vsc_host_pix_t      host_pix_out
);
    logic [31:0] wlog[$];
    logic [23:0] rlog[$];
    logic [1:0]  wait_q;
    logic [7:0]  hbyte_q;
    wire         pend = mem_req_in.rd || mem_req_in.wr;
    wire         hit  = pend && !mem_ack_out && (wait_q == slow_in);
    // ack after slow_in idle cycles; read data is junk outside the ack cycle
    always @(posedge mclk_in) begin
        mem_ack_out   <= hit && !sys_rst_in;
        mem_rdata_out <= sys_rst_in ? 8'h3c : hit ? (mem_req_in.addr[7:0] ^ 8'h5a) : ~mem_rdata_out;
        wait_q        <= (sys_rst_in || !pend || hit || mem_ack_out) ? 2'h0 : wait_q + 2'h1;
        if (hit && !sys_rst_in && mem_req_in.wr) wlog.push_back({mem_req_in.addr, mem_req_in.wdata});
        if (hit && !sys_rst_in && mem_req_in.rd) rlog.push_back(mem_req_in.addr);
    end
    // host bytes count up from 10; a taken byte is replaced at once
    always @(posedge mclk_in) begin
        hbyte_q <= sys_rst_in ? 8'h10 : hbyte_q + {7'h0, host_ready_in};
    end
    assign host_pix_out = '{valid: !sys_rst_in, data: hbyte_q};
endmodule : vsc_far_model
`default_nettype wire

// ==== testbench/video_scaler_parameter_regs_tb.sv ====
// self-checking bench for the scaler parameter registers
`timescale 1ns/10ps
`default_nettype none
`include "vsc_params.svh"
module video_scaler_parameter_regs_tb
    import vsc_pkg::*;
;
    logic          mclk_in, sys_rst_in, reg_wr_in, reg_rd_in, start_in, busy_out;
    logic          filter_enable_in, key_mask_enable_in, key_mask_in, host_ready_out, mem_ack_in;
    logic [15:0]   reg_addr_in;
    logic [31:0]   reg_wdata_in, reg_rdata_out;
    logic [11:0]   dda_init_in;
    logic [7:0]    mem_rdata_in;
    logic [1:0]    slow;
    vsc_host_pix_t host_pix_in;
    vsc_mem_req_t  mem_req_out;
    int            errors, compares, cyc, i, s;
    logic [31:0]   msk [5] = '{`VSC_MSK_SCALE, `VSC_MSK_PITCH, `VSC_MSK_CROP, `VSC_MSK_SRC, `VSC_MSK_DST};
    logic [12:0]   stp;
    // outputs per filter code, two per source pixel: bytes 5a then 52, or 1a after a line step
    logic [31:0]   fexp [4] = '{32'h2d2d_5656, 32'h0000_1616, 32'h0b0b_2020, 32'h5a5a_1a1a};

    vsc_param_regs u_dut (.mclk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .start_in, .filter_enable_in, .key_mask_enable_in, .dda_init_in, .key_mask_in,
        .host_pix_in, .host_ready_out, .mem_req_out, .mem_ack_in, .mem_rdata_in, .busy_out);
    vsc_far_model u_far (.mclk_in, .sys_rst_in, .slow_in(slow), .mem_req_in(mem_req_out),
        .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in), .host_ready_in(host_ready_out),
        .host_pix_out(host_pix_in));

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    task automatic complete_run();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    // a hung engine must not stall the run forever
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in    <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in   <= 1'b0;
        #1 chk(reg_rdata_out, exp);
    endtask : rd
    task automatic setup(input logic [31:0] sc, pi, cr, sr, ds);
        wr(`VSC_OFF_SCALE, sc);
        wr(`VSC_OFF_PITCH, pi);
        wr(`VSC_OFF_CROP, cr);
        wr(`VSC_OFF_SRC, sr);
        wr(`VSC_OFF_DST, ds);
    endtask : setup
    task automatic run_op(input logic [23:0] dst);
        int n;
        n = 0;
        u_far.wlog.delete();
        u_far.rlog.delete();
        @(posedge mclk_in);
        start_in <= 1'b1;
        @(posedge mclk_in);
        start_in <= 1'b0;
        rd(`VSC_OFF_DST, {8'h80, dst});
        while (busy_out !== 1'b0 && n < 2000) begin
            @(posedge mclk_in);
            #1 n++;
        end
        rd(`VSC_OFF_DST, {8'h00, dst});
    endtask : run_op
    task automatic do_reset();
        @(posedge mclk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
    endtask : do_reset

    initial begin
        {sys_rst_in, reg_wr_in, reg_rd_in, start_in} = 4'h8;
        {filter_enable_in, key_mask_enable_in, key_mask_in} = 3'h0;
        reg_addr_in  = 16'h0;
        reg_wdata_in = 32'h0;
        slow         = 2'h2;
        dda_init_in  = 12'hffc;
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        // zero after reset, then all ones read back as writable bits only
        for (i = 0; i < 5; i++) rd(16'h808c + 16'(4 * i), 32'h0);
        for (i = 0; i < 5; i++) begin
            wr(16'h808c + 16'(4 * i), 32'hffff_ffff);
            rd(16'h808c + 16'(4 * i), msk[i]);
        end
        wr(16'h80a0, 32'hffff_ffff);
        rd(16'h80a0, 32'h0);
        // host source, slow memory: two bytes dropped, first output suppressed
        do_reset();
        setup(32'hc004_0000, 32'h0000_0004, 32'h0001_0004, 32'h0000_0002, 32'h0000_0200);
        run_op(24'h200);
        chk(u_far.wlog.size(), 3);
        chk(u_far.rlog.size(), 0);
        for (i = 0; i < 3; i++) chk(u_far.wlog[i], {24'h200 + 24'(4 * i), 8'h13 + 8'(i)});
        // screen source, prompt memory: reads and writes step by their pitches
        do_reset();
        slow <= 2'h0;
        setup(32'h8004_0000, 32'h0010_0008, 32'h0000_0003, 32'h0000_0100, 32'h0000_0400);
        run_op(24'h400);
        chk(u_far.wlog.size(), 3);
        for (i = 0; i < 3; i++) begin
            chk(u_far.rlog[i], {8'h0, 24'h100 + 24'(16 * i)});
            chk(u_far.wlog[i], {24'h400 + 24'(8 * i), 8'h5a ^ 8'(16 * i)});
        end
        // key high with masking on: normal sense writes video, reversed sense blocks all
        key_mask_enable_in <= 1'b1;
        key_mask_in        <= 1'b1;
        for (s = 0; s < 2; s++) begin
            wr(`VSC_OFF_SCALE, 32'h8004_0000 | (32'(s) << 29));
            run_op(24'h400);
            chk(u_far.wlog.size(), (s == 0) ? 3 : 0);
        end
        // stretch two source pixels to four from memory under each filter code; odd codes step a whole line
        filter_enable_in <= 1'b1;
        for (s = 0; s < 4; s++) begin
            stp = s[0] ? 13'h0040 : 13'h0008;
            setup(32'h0002_07fe | (32'(s) << 14), {3'h0, stp, 3'h0, stp}, 32'h4, 32'h100, 32'h600);
            run_op(24'h600);
            chk(u_far.rlog.size(), 2);
            chk(u_far.rlog[1], {8'h0, 24'h100 + 24'(stp)});
            chk(u_far.wlog.size(), 4);
            for (i = 0; i < 4; i++) begin
                chk(u_far.wlog[i], {24'h600 + 24'(stp) * 24'(i), fexp[s][31 - 8 * i -: 8]});
            end
        end
        complete_run();
    end
endmodule : video_scaler_parameter_regs_tb
`default_nettype wire
